/* File: rtl/sp_serial_port.sv */
`timescale 1ns/1ps
module sp_serial_port #(
  parameter int M0_FIXED_DIV = sp_pkg::M0_FIXED_DIV
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic multiproc_enable,
  input wire logic receive_enable,
  input wire logic tx_ninth_bit,
  input wire logic framing_check_select,
  input wire logic baud_doubler,
  input wire logic brg_prescale_bypass,
  input wire logic baud_gen_run,
  input wire logic mode0_clock_source,
  input wire logic rx_clk_from_brg,
  input wire logic tx_clk_from_brg,
  input wire logic [7:0] brg_reload,
  input wire logic timer1_overflow,
  input wire logic address_write,
  input wire logic address_mask_write,
  input wire logic [7:0] address_wdata,
  input wire logic buffer_write,
  input wire logic [7:0] buffer_wdata,
  input wire logic transmit_done_clear,
  input wire logic receive_done_clear,
  input wire logic framing_error_clear,
  input wire logic rxd_in,
  output logic [7:0] serial_buffer,
  output logic rx_ninth_bit,
  output logic transmit_done_flag,
  output logic receive_done_flag,
  output logic framing_error_flag,
  output logic [7:0] own_address_reg,
  output logic [7:0] address_mask_reg,
  output logic tx_busy,
  output logic rx_busy,
  output logic txd_out,
  output logic rxd_out,
  output logic rxd_oe
);
  localparam logic [7:0] FD_LAST = 8'(M0_FIXED_DIV - 1);

  logic [1:0] mode;
  logic mode0;
  logic mode1;
  logic brg_ovf;
  logic addr_match;
  logic mp_on;
  // baud ticks
  logic tx_src, rx_src, tx_half, rx_half, tx_tick, rx_tick;
  logic m0_src, m0_half, m0_tick;
  logic [7:0] fixed_div;
  // mode 0 shifter
  logic m0_active, m0_is_rx, m0_clk, m0_last;
  logic [3:0] m0_cnt;
  logic [7:0] m0_shift;
  // async transmitter
  logic tx_run;
  logic [10:0] tx_shift;
  logic [3:0] tx_os, tx_bits, tx_frame_last;
  logic tx_end;
  // async receiver
  sp_pkg::sp_rx_state_t rx_st;
  logic [3:0] rx_os, rx_bits;
  logic [7:0] rx_shift, rx_byte;
  logic rxd_prev, rx_ninth_q, rx_loaded;
  logic rx_sample, last_data_evt, stop_evt, late;
  logic rx_evt, rx_rb8, rx_accept, fe_set;

  assign mode = {mode_select_hi, mode_select_lo};
  assign mode0 = mode == sp_pkg::MODE_SHIFT;
  assign mode1 = mode == sp_pkg::MODE_8BIT;
  assign mp_on = multiproc_enable & ~mode0;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  sp_brg u_brg (
    .clock(clock),
    .nrst(nrst),
    .run(baud_gen_run),
    .prescale_bypass(brg_prescale_bypass),
    .reload(brg_reload),
    .overflow(brg_ovf)
  );

  sp_addr_match u_match (
    .addr_byte(rx_byte),
    .own_address(own_address_reg),
    .address_mask(address_mask_reg),
    .match(addr_match)
  );

  // ----------------------------------------
  // address registers
  // ----------------------------------------
  // reset to zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      own_address_reg <= sp_pkg::ADDR_RESET;
      address_mask_reg <= sp_pkg::MASK_RESET;
    end else begin
      if (address_write) begin
        own_address_reg <= address_wdata;
      end
      if (address_mask_write) begin
        address_mask_reg <= address_wdata;
      end
    end
  end

  // ----------------------------------------
  // baud tick generation
  // ----------------------------------------
  // every clock in mode 2, else timer 1 or generator source
  always_comb begin
    if (mode == sp_pkg::MODE_9FIXED) begin
      tx_src = 1'b1;
      rx_src = 1'b1;
    end else begin
      tx_src = tx_clk_from_brg ? brg_ovf : timer1_overflow;
      rx_src = rx_clk_from_brg ? brg_ovf : timer1_overflow;
    end
  end

  assign tx_tick = tx_src & (baud_doubler | tx_half);
  assign rx_tick = rx_src & (baud_doubler | rx_half);
  assign m0_src = mode0_clock_source ? brg_ovf : (fixed_div == FD_LAST);
  assign m0_tick = m0_src & (baud_doubler | m0_half);

  // halving toggles and fixed divider
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_half <= 1'b0;
      rx_half <= 1'b0;
      m0_half <= 1'b0;
      fixed_div <= 8'h00;
    end else begin
      if (tx_src) begin
        tx_half <= ~tx_half;
      end
      if (rx_src) begin
        rx_half <= ~rx_half;
      end
      if (m0_src) begin
        m0_half <= ~m0_half;
      end
      fixed_div <= (fixed_div == FD_LAST) ? 8'h00 : fixed_div + 8'h01;
    end
  end

  // ----------------------------------------
  // mode 0 shifter
  // ----------------------------------------
  assign m0_last = m0_active & m0_tick & ~m0_clk &
                   (m0_cnt == sp_pkg::DATA_LAST);

  // clock on txd, data on rxd
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      m0_active <= 1'b0;
      m0_is_rx <= 1'b0;
      m0_clk <= 1'b1;
      m0_cnt <= 4'h0;
      m0_shift <= 8'h00;
      rxd_out <= 1'b1;
    end else if (!m0_active) begin
      m0_clk <= 1'b1;
      if (mode0 && buffer_write) begin
        m0_active <= 1'b1;
        m0_is_rx <= 1'b0;
        m0_cnt <= 4'h0;
        m0_shift <= buffer_wdata;
        rxd_out <= buffer_wdata[0];
      end else if (mode0 && receive_enable && !receive_done_flag) begin
        m0_active <= 1'b1;
        m0_is_rx <= 1'b1;
        m0_cnt <= 4'h0;
      end
    end else if (m0_tick) begin
      if (m0_clk) begin
        m0_clk <= 1'b0;
      end else begin
        m0_clk <= 1'b1;
        if (m0_is_rx) begin
          m0_shift <= {rxd_in, m0_shift[7:1]};
        end else begin
          m0_shift <= {1'b0, m0_shift[7:1]};
        end
        if (m0_cnt == sp_pkg::DATA_LAST) begin
          m0_active <= 1'b0;
          rxd_out <= 1'b1;
        end else begin
          m0_cnt <= m0_cnt + 4'h1;
          rxd_out <= m0_is_rx ? 1'b1 : m0_shift[1];
        end
      end
    end
  end

  // ----------------------------------------
  // async transmitter
  // ----------------------------------------
  // ten-bit frame in mode 1
  assign tx_frame_last = mode1 ? sp_pkg::FRAME_BITS_M1 - 4'h1
                               : sp_pkg::FRAME_BITS_M23 - 4'h1;
  assign tx_end = tx_run & tx_tick & (tx_os == sp_pkg::OVS_LAST) &
                  (tx_bits == tx_frame_last);

  // frame shift-out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_run <= 1'b0;
      tx_shift <= '1;
      tx_os <= 4'h0;
      tx_bits <= 4'h0;
    end else if (!tx_run) begin
      if (!mode0 && buffer_write) begin
        tx_run <= 1'b1;
        tx_shift <= {1'b1, mode1 | tx_ninth_bit, buffer_wdata, 1'b0};
        tx_os <= 4'h0;
        tx_bits <= 4'h0;
      end
    end else if (tx_tick) begin
      tx_os <= tx_os + 4'h1;
      if (tx_os == sp_pkg::OVS_LAST) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        if (tx_bits == tx_frame_last) begin
          tx_run <= 1'b0;
        end else begin
          tx_bits <= tx_bits + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // async receiver
  // ----------------------------------------
  assign rx_sample = rx_tick & (rx_os == sp_pkg::SAMPLE_POINT);
  assign last_data_evt = rx_sample &
    (((rx_st == sp_pkg::SP_RX_DATA) & (rx_bits == sp_pkg::DATA_LAST) & mode1)
     | (rx_st == sp_pkg::SP_RX_NINTH));
  assign stop_evt = rx_sample & (rx_st == sp_pkg::SP_RX_STOP);
  assign late = framing_check_select | (mode1 & mp_on);
  assign rx_evt = late ? stop_evt : last_data_evt;
  assign rx_byte = (rx_st == sp_pkg::SP_RX_DATA)
                 ? {rxd_in, rx_shift[7:1]} : rx_shift;
  // stop as ninth in mode 1
  assign rx_rb8 = ((rx_st == sp_pkg::SP_RX_STOP) & mode1) |
                  (rx_st == sp_pkg::SP_RX_NINTH) ? rxd_in : rx_ninth_q;
  assign rx_accept = rx_evt & ~receive_done_flag &
                     (~mp_on | (rx_rb8 & addr_match));
  assign fe_set = stop_evt & framing_check_select & ~rxd_in;

  // receive state machine
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_st <= sp_pkg::SP_RX_IDLE;
      rx_os <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift <= 8'h00;
      rx_ninth_q <= 1'b0;
      rxd_prev <= 1'b1;
    end else begin
      rxd_prev <= rxd_in;
      if (rx_tick && rx_st != sp_pkg::SP_RX_IDLE) begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_st)
        sp_pkg::SP_RX_IDLE: begin
          if (receive_enable && !mode0 && rxd_prev && !rxd_in) begin
            rx_st <= sp_pkg::SP_RX_START;
            rx_os <= 4'h0;
          end
        end
        sp_pkg::SP_RX_START: begin
          if (rx_sample) begin
            rx_st <= rxd_in ? sp_pkg::SP_RX_IDLE : sp_pkg::SP_RX_DATA;
            rx_bits <= 4'h0;
          end
        end
        sp_pkg::SP_RX_DATA: begin
          if (rx_sample) begin
            rx_shift <= {rxd_in, rx_shift[7:1]};
            if (rx_bits != sp_pkg::DATA_LAST) begin
              rx_bits <= rx_bits + 4'h1;
            end else if (mode1) begin
              rx_st <= sp_pkg::SP_RX_STOP;
            end else begin
              rx_st <= sp_pkg::SP_RX_NINTH;
            end
          end
        end
        sp_pkg::SP_RX_NINTH: begin
          if (rx_sample) begin
            rx_ninth_q <= rxd_in;
            rx_st <= sp_pkg::SP_RX_STOP;
          end
        end
        sp_pkg::SP_RX_STOP: begin
          if (rx_sample) begin
            rx_st <= sp_pkg::SP_RX_IDLE;
          end
        end
        default: rx_st <= sp_pkg::SP_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  // loads from either receive path
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial_buffer <= 8'h00;
      rx_ninth_bit <= 1'b0;
      rx_loaded <= 1'b0;
    end else if (m0_last && m0_is_rx) begin
      serial_buffer <= {rxd_in, m0_shift[7:1]};
    end else if (rx_accept) begin
      serial_buffer <= rx_byte;
      rx_ninth_bit <= rx_rb8;
      rx_loaded <= mode1 & ~stop_evt;
    end else if (stop_evt) begin
      // mode 1 early load takes stop later
      if (rx_loaded) begin
        rx_ninth_bit <= rxd_in;
      end
      rx_loaded <= 1'b0;
    end
  end

  // ----------------------------------------
  // status flags, set beats clear
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      transmit_done_flag <= (m0_last & ~m0_is_rx) | tx_end |
                            (transmit_done_flag & ~transmit_done_clear);
      receive_done_flag <= (m0_last & m0_is_rx) | rx_accept |
                           (receive_done_flag & ~receive_done_clear);
      framing_error_flag <= fe_set |
                            (framing_error_flag & ~framing_error_clear);
    end
  end

  // ----------------------------------------
  // pins and status
  // ----------------------------------------
  assign txd_out = mode0 ? m0_clk : tx_shift[0];
  assign rxd_oe = mode0 & ~(m0_active & m0_is_rx);
  assign tx_busy = tx_run | (m0_active & ~m0_is_rx);
  assign rx_busy = (rx_st != sp_pkg::SP_RX_IDLE) | (m0_active & m0_is_rx);
endmodule

/* File: common/sp_pkg.sv */
// Notes on behaviour
// - stop-bit checking only in modes 1-3 with framing check select set
// - with checking on, an invalid stop bit sets the framing error flag
// - framing error flag sticky until cleared or reset; good frames keep it
// - with checking on, receive-done rises at the stop bit
// - multiproc enable filters command frames by address match
// - given or broadcast address match both count as addressed
// - mode 1 recognition uses stop as ninth bit; needs valid stop
// - multiproc enable has no effect in mode 0
// - given address is own address with mask zeros as don't care
// - broadcast is own OR mask; zero bits are don't care
// - own address and mask reset to zero, accepting any address
// - timer 1 overflow can time the serial bit rate
// - baud doubler doubles the generated baud rate
// - baud generator is 8-bit auto-reload, clock or clock/6
// - baud generator counts only while its run bit is set
// - mode 0: txd gives eight clocks, rxd carries data lsb first
// - buffer write in mode 0 starts a shift-out
// - each mode 0 clock is high then low; bit n in cycle n
// - after the eighth bit rxd goes high and transmit-done sets
// - mode 0 receive samples eight bits then sets receive-done
// - mode 0 rate is fixed or from the baud generator
// - mode 1 frame: start, eight data, stop
// - modes 2 and 3 frame: start, eight data, ninth bit, stop
package sp_pkg;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;
  localparam logic [1:0] MODE_9FIXED = 2'h2;
  localparam int BRG_PRESCALE = 6;
  localparam int M0_FIXED_DIV = 6;
  localparam logic [7:0] BRG_TOP = 8'hff;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] FRAME_BITS_M1 = 4'ha;
  localparam logic [3:0] FRAME_BITS_M23 = 4'hb;
  typedef enum logic [2:0] {
    SP_RX_IDLE, SP_RX_START, SP_RX_DATA, SP_RX_NINTH, SP_RX_STOP
  } sp_rx_state_t;
endpackage

/* File: rtl/sp_brg.sv */
`timescale 1ns/1ps
module sp_brg #(
  parameter int PRESCALE = sp_pkg::BRG_PRESCALE
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  input wire logic prescale_bypass,
  input wire logic [7:0] reload,
  output logic overflow
);
  localparam logic [2:0] PS_LAST = 3'(PRESCALE - 1);
  logic [2:0] prescale;
  logic [7:0] count;
  logic step;

  // ----------------------------------------
  // input clock: direct or divided
  // ----------------------------------------
  // prescale select
  assign step = prescale_bypass | (prescale == PS_LAST);

  // prescaler free runs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale <= 3'h0;
    end else if (prescale == PS_LAST) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  // ----------------------------------------
  // auto-reload counter
  // ----------------------------------------
  // gated by run
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= 8'h00;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (run && step) begin
        if (count == sp_pkg::BRG_TOP) begin
          count <= reload;
          overflow <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule

/* File: rtl/sp_addr_match.sv */
`timescale 1ns/1ps
module sp_addr_match (
  input wire logic [7:0] addr_byte,
  input wire logic [7:0] own_address,
  input wire logic [7:0] address_mask,
  output logic match
);
  logic [7:0] bcast;
  logic given_hit;
  logic bcast_hit;

  // ----------------------------------------
  // bitwise compare with don't cares
  // ----------------------------------------
  // mask zeros ignored
  assign given_hit = ((addr_byte ^ own_address) & address_mask) == 8'h00;
  assign bcast = own_address | address_mask;
  assign bcast_hit = ((addr_byte ^ bcast) & bcast) == 8'h00;
  assign match = given_hit | bcast_hit;
endmodule

/* File: test/sp_serial_port_sva.sv */
`timescale 1ns/1ps
module sp_serial_port_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic framing_check_select,
  input wire logic address_write,
  input wire logic address_mask_write,
  input wire logic [7:0] address_wdata,
  input wire logic buffer_write,
  input wire logic [7:0] buffer_wdata,
  input wire logic framing_error_clear,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic txd_out,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic transmit_done_flag,
  input wire logic framing_error_flag,
  input wire logic [7:0] own_address_reg,
  input wire logic [7:0] address_mask_reg
);
  logic m0;
  logic d0;
  // mode 0 decode and first bit of the written byte
  assign m0 = !mode_select_hi && !mode_select_lo;
  assign d0 = buffer_wdata[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ------------------------------
  // transfer starts
  // ------------------------------
  sequence m0_go;
    buffer_write && !tx_busy && !rx_busy && m0;
  endsequence
  sequence async_go;
    buffer_write && !tx_busy && !m0;
  endsequence
  addr_load_a: assert property (
    address_write |=> own_address_reg == $past(address_wdata))
    else $error("own address not loaded");
  mask_load_a: assert property (
    address_mask_write |=> address_mask_reg == $past(address_wdata))
    else $error("mask not loaded");
  addr_hold_a: assert property (
    !address_write && !address_mask_write |=>
      $stable(own_address_reg) && $stable(address_mask_reg))
    else $error("address changed unasked");
  fe_sticky_a: assert property (
    framing_error_flag && !framing_error_clear |=> framing_error_flag)
    else $error("framing flag dropped");
  fe_cause_a: assert property (
    $rose(framing_error_flag) |-> $past(framing_check_select) && !$past(m0))
    else $error("framing flag without check");
  m0_start_a: assert property (
    m0_go |=> tx_busy && txd_out && rxd_oe && rxd_out == $past(d0))
    else $error("mode 0 start wrong");
  async_start_a: assert property (
    async_go |=> (tx_busy && !txd_out) [*8])
    else $error("start bit wrong");
  done_busy_a: assert property (
    $fell(tx_busy) |-> transmit_done_flag)
    else $error("end without done");
  m0_end_a: assert property (
    $fell(tx_busy) && m0 |-> rxd_out && txd_out)
    else $error("mode 0 end levels");
  m0_rx_oe_a: assert property (
    rx_busy && m0 |-> !rxd_oe)
    else $error("rxd driven in receive");
endmodule
bind sp_serial_port sp_serial_port_sva i_sva (
  .clock(clock), .nrst(nrst), .mode_select_hi(mode_select_hi),
  .mode_select_lo(mode_select_lo), .tx_busy(tx_busy), .rx_busy(rx_busy),
  .framing_check_select(framing_check_select), .rxd_oe(rxd_oe),
  .address_write(address_write), .address_mask_write(address_mask_write),
  .address_wdata(address_wdata), .buffer_write(buffer_write),
  .buffer_wdata(buffer_wdata), .framing_error_clear(framing_error_clear),
  .txd_out(txd_out), .rxd_out(rxd_out),
  .transmit_done_flag(transmit_done_flag),
  .framing_error_flag(framing_error_flag),
  .own_address_reg(own_address_reg), .address_mask_reg(address_mask_reg));

/* File: test/sp_line_model.sv */
`timescale 1ns/1ps
module sp_line_model (
  input wire logic clock,
  input wire logic txd_out,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_in
);
  logic line = 1'b1;
  logic txd_d = 1'b1;
  logic [7:0] m0_data = 8'h00;
  // pin level: device drive wins, else our drive, idle pulled high
  assign rxd_in = rxd_oe ? rxd_out : line;
  // shifter moves on after each rising shift clock
  always @(posedge clock) begin
    txd_d <= txd_out;
    if (!rxd_oe && !txd_d && txd_out) begin
      m0_data <= {1'b1, m0_data[7:1]};
      line <= m0_data[1];
    end
  end
  // load the byte for a mode 0 reception
  task automatic m0_load(input logic [7:0] d);
    m0_data <= d;
    line <= d[0];
  endtask
  // start, data lsb first, ninth, stop
  // in mode 1 the ninth slot carries the stop bit
  task automatic send(input logic [7:0] d, input logic nb,
      input logic stp, input int bl);
    logic [10:0] f;
    f = {stp, nb, d, 1'b0};
    @(posedge clock);
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (bl) @(posedge clock);
    end
    line <= 1'b1;
  endtask
endmodule

/* File: test/sp_serial_port_bench.sv */
`timescale 1ns/1ps
module sp_serial_port_bench;
  logic clock, nrst, rxd_in, mode_select_hi, mode_select_lo;
  logic multiproc_enable, receive_enable, framing_check_select;
  logic baud_doubler, brg_prescale_bypass, baud_gen_run, tx_clk_from_brg;
  logic timer1_overflow, address_write, address_mask_write, buffer_write;
  logic transmit_done_clear, receive_done_clear, framing_error_clear;
  logic [7:0] brg_reload, address_wdata, buffer_wdata;
  logic [7:0] serial_buffer, own_address_reg, address_mask_reg;
  logic transmit_done_flag, receive_done_flag, framing_error_flag;
  logic tx_busy, rx_busy, txd_out, rxd_out, rxd_oe, rx_ninth_bit;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int bl = 16;
  sp_serial_port #(.M0_FIXED_DIV(2)) i_dut (
    .clock(clock), .nrst(nrst), .mode_select_hi(mode_select_hi),
    .mode_select_lo(mode_select_lo), .multiproc_enable(multiproc_enable),
    .receive_enable(receive_enable), .tx_ninth_bit(1'b1),
    .framing_check_select(framing_check_select),
    .baud_doubler(baud_doubler), .brg_prescale_bypass(brg_prescale_bypass),
    .baud_gen_run(baud_gen_run), .mode0_clock_source(1'b0),
    .rx_clk_from_brg(1'b0), .tx_clk_from_brg(tx_clk_from_brg),
    .brg_reload(brg_reload), .timer1_overflow(timer1_overflow),
    .address_write(address_write), .address_mask_write(address_mask_write),
    .address_wdata(address_wdata), .buffer_write(buffer_write),
    .buffer_wdata(buffer_wdata), .transmit_done_clear(transmit_done_clear),
    .receive_done_clear(receive_done_clear),
    .framing_error_clear(framing_error_clear), .rxd_in(rxd_in),
    .serial_buffer(serial_buffer), .rx_ninth_bit(rx_ninth_bit),
    .transmit_done_flag(transmit_done_flag),
    .receive_done_flag(receive_done_flag),
    .framing_error_flag(framing_error_flag),
    .own_address_reg(own_address_reg), .address_mask_reg(address_mask_reg),
    .tx_busy(tx_busy), .rx_busy(rx_busy), .txd_out(txd_out),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe));
  sp_line_model i_line (.clock(clock), .txd_out(txd_out),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in));
  // ------------------------------
  // clock, timer overflow pulses, hang guard
  // ------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    timer1_overflow <= !timer1_overflow;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miss("timeout");
      test_done();
    end
  end
  // ------------------------------
  // reporting and compares
  // ------------------------------
  task automatic miss(input string m);
    n_errors++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask
  task automatic cmp_bit(input logic a, input logic e, input string m);
    checks++;
    if (a !== e) miss(m);
  endtask
  task automatic cmp_byte(input logic [7:0] a, input logic [7:0] e,
      input string m);
    checks++;
    if (a !== e) miss(m);
  endtask
  task automatic cmp_range(input int a, input int e, input string m);
    checks++;
    if (a < e - 24 || a > e + 24) miss(m);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------
  // drivers
  // ------------------------------
  task automatic strobe(input int w, input logic [7:0] d);
    @(posedge clock);
    address_wdata <= d;
    buffer_wdata <= d;
    case (w)
      0: buffer_write <= 1'b1;
      1: address_write <= 1'b1;
      2: address_mask_write <= 1'b1;
      3: receive_done_clear <= 1'b1;
      4: transmit_done_clear <= 1'b1;
      default: framing_error_clear <= 1'b1;
    endcase
    @(posedge clock);
    {buffer_write, address_write, address_mask_write} <= 3'h0;
    {receive_done_clear, transmit_done_clear, framing_error_clear} <= 3'h0;
  endtask
  task automatic cfg(input logic [1:0] m, input logic mp, input logic fc);
    @(posedge clock);
    {mode_select_hi, mode_select_lo} <= m;
    multiproc_enable <= mp;
    framing_check_select <= fc;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: sel = transmit_done_flag;
      1: sel = receive_done_flag;
      2: sel = txd_out;
      default: sel = !txd_out;
    endcase
  endfunction
  task automatic wait_on(input int w, output int n);
    n = 0;
    while (sel(w) !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 4000) miss("wait too long");
  endtask
  // one frame in; e is the done flag expected just before stop sampling
  task automatic rx_frame(input logic [7:0] d, input logic nb,
      input logic stp, input logic ld, input logic e);
    fork
      i_line.send(d, nb, stp, bl);
      begin
        repeat ((bl > 16 ? 9 : 10) * bl + 3) @(negedge clock);
        cmp_bit(receive_done_flag, e, "done timing");
      end
    join
    repeat (2) @(negedge clock);
    cmp_bit(receive_done_flag, ld, "frame accept");
    if (ld) cmp_byte(serial_buffer, d, "frame data");
    if (ld) cmp_bit(rx_ninth_bit, nb, "ninth bit");
    if (receive_done_flag === 1'b1) strobe(3, 8'h00);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    @(negedge clock);
    cmp_byte(own_address_reg, 8'h00, "own reset");
    cmp_byte(address_mask_reg, 8'h00, "mask reset");
    cmp_bit(framing_error_flag, 1'b0, "fe reset");
    $display("reset test ended");
  endtask
  task automatic t_m0(input logic [7:0] d, input logic [7:0] r);
    int n;
    cfg(2'h0, 1'b1, 1'b0);
    strobe(0, d);
    for (int k = 0; k < 8; k++) begin
      wait_on(3, n);
      cmp_bit(rxd_out, d[k], "m0 bit");
      wait_on(2, n);
    end
    wait_on(0, n);
    cmp_bit(rxd_out, 1'b1, "m0 end");
    strobe(4, 8'h00);
    i_line.m0_load(r);
    receive_enable <= 1'b1;
    wait_on(1, n);
    @(posedge clock);
    receive_enable <= 1'b0;
    i_line.m0_load(8'hff);
    cmp_byte(serial_buffer, r, "m0 rx");
    strobe(3, 8'h00);
    $display("mode 0 test ended");
  endtask
  task automatic t_frame();
    cfg(2'h2, 1'b0, 1'b1);
    receive_enable <= 1'b1;
    rx_frame(8'h5a, 1'b0, 1'b0, 1'b1, 1'b0);
    cmp_bit(framing_error_flag, 1'b1, "fe set");
    rx_frame(8'ha5, 1'b1, 1'b1, 1'b1, 1'b0);
    cmp_bit(framing_error_flag, 1'b1, "fe kept");
    strobe(5, 8'h00);
    @(negedge clock);
    cmp_bit(framing_error_flag, 1'b0, "fe clear");
    cfg(2'h2, 1'b0, 1'b0);
    rx_frame(8'h0f, 1'b0, 1'b0, 1'b1, 1'b1);
    cmp_bit(framing_error_flag, 1'b0, "fe off");
    $display("framing test ended");
  endtask
  task automatic t_addr();
    cfg(2'h2, 1'b1, 1'b0);
    rx_frame(8'h13, 1'b1, 1'b1, 1'b1, 1'b1);
    strobe(1, 8'h56);
    strobe(2, 8'hfc);
    rx_frame(8'h57, 1'b1, 1'b1, 1'b1, 1'b1);
    rx_frame(8'hfe, 1'b1, 1'b1, 1'b1, 1'b1);
    rx_frame(8'h5e, 1'b1, 1'b1, 1'b0, 1'b0);
    rx_frame(8'h57, 1'b0, 1'b1, 1'b0, 1'b0);
    strobe(2, 8'hff);
    rx_frame(8'h57, 1'b1, 1'b1, 1'b0, 1'b0);
    rx_frame(8'hff, 1'b1, 1'b1, 1'b1, 1'b1);
    cfg(2'h1, 1'b1, 1'b0);
    bl = 32;
    rx_frame(8'h56, 1'b1, 1'b1, 1'b1, 1'b0);
    rx_frame(8'h56, 1'b0, 1'b1, 1'b0, 1'b0);
    $display("address test ended");
  endtask
  task automatic t_baud();
    int n;
    logic [2:0] cf [4] = '{3'h5, 3'h7, 3'h6, 3'h3};
    int bt [4] = '{64, 32, 192, 32};
    @(posedge clock);
    tx_clk_from_brg <= 1'b1;
    baud_gen_run <= 1'b0;
    strobe(0, 8'h81);
    repeat (400) @(negedge clock);
    cmp_bit(txd_out, 1'b0, "held start");
    @(posedge clock);
    baud_gen_run <= 1'b1;
    wait_on(0, n);
    strobe(4, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {tx_clk_from_brg, baud_doubler, brg_prescale_bypass} <= cf[i];
      strobe(0, 8'h3c);
      wait_on(0, n);
      cmp_range(n, 10 * bt[i], "frame length");
      strobe(4, 8'h00);
    end
    $display("baud test ended");
  endtask
  initial begin
    nrst = 1'b0;
    {mode_select_hi, mode_select_lo, multiproc_enable} = 3'h0;
    {receive_enable, framing_check_select, tx_clk_from_brg} = 3'h0;
    {baud_doubler, brg_prescale_bypass, baud_gen_run} = 3'h7;
    {timer1_overflow, address_write, address_mask_write} = 3'h0;
    {buffer_write, transmit_done_clear, receive_done_clear} = 3'h0;
    framing_error_clear = 1'b0;
    brg_reload = 8'hfe;
    address_wdata = 8'h00;
    buffer_wdata = 8'h00;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_m0(8'hb4, 8'h3c);
    t_frame();
    t_addr();
    t_baud();
    test_done();
  end
endmodule
